// File: hdl/interrupt_context_save_restore.sv
// two-level interrupt context store with software-visible shadow bank
// assumes the core gives one-cycle entry/exit pulses and holds its
// register values steady in the entry cycle; all inputs share clk
`timescale 1ns/1ps

// Behaviour
// - two saved levels: main and low ISR
// - PC goes to hardware stack, not shadows
// - save status, work, bank, pointers, product, latch
// - load work with vector after capture
// - save/restore follow current level and order
// - multi-vector enable does not change behaviour
// - priority off: only main context saved
// - shadows live in bank 56, hardware written
// - one address set shows either level
// - selector clear main, set low ISR
// - high ISR exit restores low context if it preempted a low ISR, else main
// - low ISR exit restores main context
// - software writes are what gets restored
module interrupt_context_save_restore
  import ctx_save_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        priorityEnable,
  input  wire logic        multiVectorEnable,
  input  wire logic        intEntry,
  input  wire logic        intEntryHigh,
  input  wire logic [7:0]  vectorNum,
  input  wire logic [20:0] pcValue,
  input  wire logic        intExit,
  input  wire cpu_ctx_t    cpuRegs,
  input  wire logic        selWrite,
  input  wire logic        selWdata,
  input  wire shadow_req_t shadowReq,
  output logic             pcPush,
  output logic [20:0]      pcPushData,
  output logic             restoreValid,
  output cpu_ctx_t         restoreRegs,
  output logic             workLoad,
  output logic [7:0]       workLoadData,
  output logic [7:0]       shadowRdata,
  output logic             shadowSelect,
  output run_level_t       runLevel
);

  // ==========================================================
  // context storage and level tracking
  cpu_ctx_t   mainCtx_reg;
  cpu_ctx_t   lowCtx_reg;
  run_level_t level_reg;
  logic       sel_reg;
  logic       lowNested_reg;
  logic       saveMain;
  logic       saveLow;
  logic       exitHigh;
  logic       exitLow;
  logic       bankHit;
  logic [7:0] rdByte;

  // multi-vector enable is deliberately unused by save/restore
  logic       mvUnused;
  assign mvUnused = multiVectorEnable;

  assign bankHit = (shadowReq.bank == SHADOW_BANK);

  // save target follows the level being interrupted
  always_comb begin
    saveMain = 1'b0;
    saveLow  = 1'b0;
    if (intEntry) begin
      unique case (level_reg)
        LVL_MAIN: saveMain = 1'b1;
        LVL_LOW:  saveLow  = priorityEnable && intEntryHigh;
        LVL_HIGH: saveLow  = 1'b0;
      endcase
    end
  end

  assign exitHigh = intExit && (level_reg == LVL_HIGH);
  assign exitLow  = intExit && (level_reg == LVL_LOW);

  // ==========================================================
  // running interrupt level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_reg <= LVL_MAIN;
    end else if (intEntry && level_reg == LVL_MAIN) begin
      // without priority every interrupt runs at one level
      level_reg <= (priorityEnable && intEntryHigh) ? LVL_HIGH : LVL_LOW;
    end else if (saveLow) begin
      level_reg <= LVL_HIGH;
    end else if (exitHigh) begin
      // return to low only if a low ISR was preempted
      level_reg <= lowNested_reg ? LVL_LOW : LVL_MAIN;
    end else if (exitLow) begin
      level_reg <= LVL_MAIN;
    end
  end

  // high entered straight from main leaves no low context to reload
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lowNested_reg <= 1'b0;
    end else if (saveLow) begin
      lowNested_reg <= 1'b1;
    end else if (exitHigh) begin
      lowNested_reg <= 1'b0;
    end
  end

  // ==========================================================
  // shadow selector
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_reg <= SEL_RESET;
    end else if (selWrite) begin
      sel_reg <= selWdata;
    end
  end

  // ==========================================================
  // byte access helpers
  function automatic cpu_ctx_t putByte(cpu_ctx_t c, logic [3:0] i,
                                       logic [7:0] d);
    cpu_ctx_t r;
    r = c;
    unique case (i)
      OFS_STATUS:  r.status  = d;
      OFS_WORK:    r.work    = d;
      OFS_BANKSEL: r.bankSel = d;
      OFS_FSEL0L:  r.fsel0L  = d;
      OFS_FSEL0H:  r.fsel0H  = d;
      OFS_FSEL1L:  r.fsel1L  = d;
      OFS_FSEL1H:  r.fsel1H  = d;
      OFS_FSEL2L:  r.fsel2L  = d;
      OFS_FSEL2H:  r.fsel2H  = d;
      OFS_PRODL:   r.prodL   = d;
      OFS_PRODH:   r.prodH   = d;
      OFS_PCLH:    r.pcLatH  = d;
      OFS_PCLU:    r.pcLatU  = d;
      default:     r = c;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] getByte(cpu_ctx_t c, logic [3:0] i);
    logic [7:0] r;
    r = BYTE_ZERO;
    unique case (i)
      OFS_STATUS:  r = c.status;
      OFS_WORK:    r = c.work;
      OFS_BANKSEL: r = c.bankSel;
      OFS_FSEL0L:  r = c.fsel0L;
      OFS_FSEL0H:  r = c.fsel0H;
      OFS_FSEL1L:  r = c.fsel1L;
      OFS_FSEL1H:  r = c.fsel1H;
      OFS_FSEL2L:  r = c.fsel2L;
      OFS_FSEL2H:  r = c.fsel2H;
      OFS_PRODL:   r = c.prodL;
      OFS_PRODH:   r = c.prodH;
      OFS_PCLH:    r = c.pcLatH;
      OFS_PCLU:    r = c.pcLatU;
      default:     r = BYTE_ZERO;
    endcase
    return r;
  endfunction

  // ==========================================================
  // saved contexts: hardware save has priority over software write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mainCtx_reg <= CTX_ZERO;
    end else if (saveMain) begin
      mainCtx_reg <= cpuRegs;
    end else if (shadowReq.wr && bankHit && !sel_reg) begin
      mainCtx_reg <= putByte(mainCtx_reg, shadowReq.idx,
                             shadowReq.wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lowCtx_reg <= CTX_ZERO;
    end else if (saveLow) begin
      lowCtx_reg <= cpuRegs;
    end else if (shadowReq.wr && bankHit && sel_reg) begin
      lowCtx_reg <= putByte(lowCtx_reg, shadowReq.idx,
                            shadowReq.wdata);
    end
  end

  // ==========================================================
  // shadow read port: one address set, level picked by selector
  assign rdByte = sel_reg ? getByte(lowCtx_reg, shadowReq.idx)
                          : getByte(mainCtx_reg, shadowReq.idx);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadowRdata <= BYTE_ZERO;
    end else if (shadowReq.rd && bankHit) begin
      shadowRdata <= rdByte;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadowSelect <= SEL_RESET;
    end else begin
      shadowSelect <= (selWrite) ? selWdata : sel_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      runLevel <= LVL_MAIN;
    end else begin
      runLevel <= level_reg;
    end
  end

  // ==========================================================
  // entry side: PC push and vector load
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pcPush       <= 1'b0;
      pcPushData   <= '0;
      workLoad     <= 1'b0;
      workLoadData <= BYTE_ZERO;
    end else begin
      pcPush       <= saveMain || saveLow || intEntry;
      pcPushData   <= pcValue;
      // the work byte is captured this cycle, vector loads next
      workLoad     <= intEntry;
      workLoadData <= vectorNum;
    end
  end

  // ==========================================================
  // exit side: restore from the level below
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      restoreValid <= 1'b0;
      restoreRegs  <= CTX_ZERO;
    end else begin
      restoreValid <= intExit && (exitLow || exitHigh);
      if (exitHigh && lowNested_reg) begin
        restoreRegs <= lowCtx_reg;
      end else begin
        restoreRegs <= mainCtx_reg;
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_entryFromMain;
    intEntry && level_reg == LVL_MAIN;
  endsequence

  // a same-cycle software write to the main level is its own concern
  sequence s_preemptSave;
    saveLow && !(shadowReq.wr && bankHit && !sel_reg);
  endsequence

  sequence s_idleExit;
    intExit && level_reg == LVL_MAIN;
  endsequence

  AST_VECTOR_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    intEntry |=> workLoad && workLoadData == $past(vectorNum))
    else $error("vector not loaded after entry");

  AST_MAIN_SAVE: assert property (@(posedge clk) disable iff (sys_rst)
    s_entryFromMain |=> mainCtx_reg == $past(cpuRegs))
    else $error("main context not captured");

  AST_LOW_EXIT: assert property (@(posedge clk) disable iff (sys_rst)
    exitLow |=> restoreValid && restoreRegs == $past(mainCtx_reg))
    else $error("low exit did not restore main context");

  AST_HIGH_EXIT: assert property (@(posedge clk) disable iff (sys_rst)
    exitHigh && lowNested_reg |=> restoreRegs == $past(lowCtx_reg))
    else $error("high exit did not restore low context");

  AST_NO_PRIO: assert property (@(posedge clk) disable iff (sys_rst)
    !priorityEnable && intEntry
      && !(shadowReq.wr && bankHit && sel_reg)
      |=> lowCtx_reg == $past(lowCtx_reg))
    else $error("low context saved with priority off");

  AST_PREEMPT: assert property (@(posedge clk) disable iff (sys_rst)
    s_preemptSave |=> mainCtx_reg == $past(mainCtx_reg)
      && lowCtx_reg == $past(cpuRegs))
    else $error("preempt save went to wrong level");

  AST_PC_PUSH: assert property (@(posedge clk) disable iff (sys_rst)
    intEntry |=> pcPush && pcPushData == $past(pcValue))
    else $error("pc not pushed on entry");

  AST_SEL_RESET: assert property (@(posedge clk)
    sys_rst |=> !sel_reg)
    else $error("selector not cleared by reset");

  AST_SW_WRITE: assert property (
    @(posedge clk) disable iff (sys_rst)
    shadowReq.wr && bankHit && !sel_reg && !saveMain
      && shadowReq.idx == OFS_WORK
      |=> mainCtx_reg.work == $past(shadowReq.wdata))
    else $error("shadow write not stored");

  AST_IDLE_EXIT: assert property (@(posedge clk) disable iff (sys_rst)
    s_idleExit |=> !restoreValid)
    else $error("restore issued from main level");

endmodule // interrupt_context_save_restore

// File: hdl/ctx_save_pkg.sv
// constants and carrier types for the interrupt context store
// assumes an 8-bit core with a separate hardware return-address stack
package ctx_save_pkg;

  localparam int BYTE_W   = 8;
  localparam int VEC_W    = 8;
  // shadow bank and in-bank offsets of the saved registers
  localparam logic [5:0] SHADOW_BANK = 6'h38;
  localparam int         SHADOW_IDX_W = 4;
  localparam logic [3:0] OFS_STATUS  = 4'h0;
  localparam logic [3:0] OFS_WORK    = 4'h1;
  localparam logic [3:0] OFS_BANKSEL = 4'h2;
  localparam logic [3:0] OFS_FSEL0L  = 4'h3;
  localparam logic [3:0] OFS_FSEL0H  = 4'h4;
  localparam logic [3:0] OFS_FSEL1L  = 4'h5;
  localparam logic [3:0] OFS_FSEL1H  = 4'h6;
  localparam logic [3:0] OFS_FSEL2L  = 4'h7;
  localparam logic [3:0] OFS_FSEL2H  = 4'h8;
  localparam logic [3:0] OFS_PRODL   = 4'h9;
  localparam logic [3:0] OFS_PRODH   = 4'ha;
  localparam logic [3:0] OFS_PCLH    = 4'hb;
  localparam logic [3:0] OFS_PCLU    = 4'hc;
  localparam int         CTX_BYTES   = 13;
  localparam logic       SEL_RESET   = 1'b0;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // the CPU working state that is saved and restored
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] work;
    logic [7:0] bankSel;
    logic [7:0] fsel0L;
    logic [7:0] fsel0H;
    logic [7:0] fsel1L;
    logic [7:0] fsel1H;
    logic [7:0] fsel2L;
    logic [7:0] fsel2H;
    logic [7:0] prodL;
    logic [7:0] prodH;
    logic [7:0] pcLatH;
    logic [7:0] pcLatU;
  } cpu_ctx_t;

  localparam cpu_ctx_t CTX_ZERO = '0;

  // software access to the shadow bank
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] bank;
    logic [3:0] idx;
    logic [7:0] wdata;
  } shadow_req_t;

  typedef enum logic [1:0] {
    LVL_MAIN,
    LVL_LOW,
    LVL_HIGH
  } run_level_t;

endpackage : ctx_save_pkg

// File: tb/cpu_core_model.sv
// partner model: cpu core register file beside the context store
// assumes restore and work-load pulses last one clock
`timescale 1ns/1ps
module cpu_core_model
  import ctx_save_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       loadEn,
  input  wire cpu_ctx_t   loadVal,
  input  wire logic       restoreValid,
  input  wire cpu_ctx_t   restoreRegs,
  input  wire logic       workLoad,
  input  wire logic [7:0] workLoadData,
  output cpu_ctx_t        cpuRegs
);
  // ==========================================
  // register file
  always_ff @(posedge clk) begin
    if (sys_rst) cpuRegs <= CTX_ZERO;
    else if (restoreValid) cpuRegs <= restoreRegs;
    else if (loadEn) cpuRegs <= loadVal;
    else if (workLoad) cpuRegs.work <= workLoadData;
  end
endmodule // cpu_core_model

// File: tb/testbench.sv
// self-checking bench for the interrupt context store
// assumes the core model answers restore and work-load pulses
`timescale 1ns/1ps
module testbench;
  import ctx_save_pkg::*;
  logic        clk = 1'h0, sys_rst = 1'h1, priorityEnable = 1'h1;
  logic        multiVectorEnable = 1'h0, intEntry = 1'h0;
  logic        intEntryHigh = 1'h0, intExit = 1'h0, loadEn = 1'h0;
  logic        selWrite = 1'h0, selWdata = 1'h0;
  logic        pcPush, restoreValid, workLoad, shadowSelect;
  logic [7:0]  vectorNum = 8'h00, workLoadData, shadowRdata, d;
  logic [20:0] pcValue = 21'h0, pcPushData;
  cpu_ctx_t    loadVal = CTX_ZERO, cpuRegs, restoreRegs, ctxA, ctxB;
  shadow_req_t shadowReq = '0;
  run_level_t  runLevel;
  int          fail_count = 0, checks_done = 0, cycles = 0;

  always #12.5 clk = ~clk;

  interrupt_context_save_restore u_interrupt_context_save_restore (
    .clk(clk), .sys_rst(sys_rst), .priorityEnable(priorityEnable),
    .multiVectorEnable(multiVectorEnable), .intEntry(intEntry),
    .intEntryHigh(intEntryHigh), .vectorNum(vectorNum),
    .pcValue(pcValue), .intExit(intExit), .cpuRegs(cpuRegs),
    .selWrite(selWrite), .selWdata(selWdata), .shadowReq(shadowReq),
    .pcPush(pcPush), .pcPushData(pcPushData),
    .restoreValid(restoreValid), .restoreRegs(restoreRegs),
    .workLoad(workLoad), .workLoadData(workLoadData),
    .shadowRdata(shadowRdata), .shadowSelect(shadowSelect),
    .runLevel(runLevel));

  cpu_core_model u_cpu_core_model (
    .clk(clk), .sys_rst(sys_rst), .loadEn(loadEn), .loadVal(loadVal),
    .restoreValid(restoreValid), .restoreRegs(restoreRegs),
    .workLoad(workLoad), .workLoadData(workLoadData),
    .cpuRegs(cpuRegs));

  // ==========================================
  // checking and closing
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string what, logic [103:0] seen, logic [103:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      close_out();
    end
  end

  // ==========================================
  // stimulus helpers
  function automatic cpu_ctx_t rnd();
    cpu_ctx_t c;
    for (int i = 0; i < 13; i++) c[i*8 +: 8] = 8'($urandom);
    return c;
  endfunction

  function automatic logic [7:0] byteOf(cpu_ctx_t c, int i);
    return c[(12-i)*8 +: 8];
  endfunction

  task automatic ld(cpu_ctx_t v);
    @(posedge clk);
    loadEn <= 1'h1;
    loadVal <= v;
    @(posedge clk);
    loadEn <= 1'h0;
  endtask

  task automatic entry(logic hi);
    logic [7:0]  v;
    logic [20:0] p;
    v = 8'($urandom);
    p = 21'($urandom);
    @(posedge clk);
    intEntry <= 1'h1;
    intEntryHigh <= hi;
    vectorNum <= v;
    pcValue <= p;
    @(posedge clk);
    intEntry <= 1'h0;
    #1;
    chk("pcPush", pcPush, 1'h1);
    chk("pcPushData", pcPushData, p);
    chk("workLoad", workLoad, 1'h1);
    chk("workLoadData", workLoadData, v);
  endtask

  task automatic leave(logic ok, cpu_ctx_t exp);
    @(posedge clk);
    intExit <= 1'h1;
    @(posedge clk);
    intExit <= 1'h0;
    #1;
    chk("restoreValid", restoreValid, ok);
    if (ok) chk("restoreRegs", restoreRegs, exp);
  endtask

  task automatic setSel(logic s);
    @(posedge clk);
    selWrite <= 1'h1;
    selWdata <= s;
    @(posedge clk);
    selWrite <= 1'h0;
    #1;
    chk("shadowSelect", shadowSelect, s);
  endtask

  task automatic access(logic w, logic [5:0] b, int i, logic [7:0] x);
    @(posedge clk);
    shadowReq <= '{~w, w, b, 4'(i), x};
    @(posedge clk);
    shadowReq <= '0;
    #1;
    if (!w) chk("shadowRdata", shadowRdata, x);
  endtask

  task automatic rdCtx(logic s, cpu_ctx_t exp);
    setSel(s);
    for (int i = 0; i < 13; i++)
      access(1'h0, SHADOW_BANK, i, byteOf(exp, i));
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h1791c94c));
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    #1;
    chk("shadowSelect", shadowSelect, SEL_RESET);
    chk("runLevel", runLevel, LVL_MAIN);
    for (int m = 0; m < 2; m++) begin
      multiVectorEnable <= m[0];
      priorityEnable <= 1'h1;
      ctxA = rnd();
      ld(ctxA);
      entry(1'h0);
      rdCtx(1'h0, ctxA);
      chk("runLevel", runLevel, LVL_LOW);
      ctxB = rnd();
      ld(ctxB);
      entry(1'h1);
      // a further entry while high runs must save nothing
      ld(rnd());
      entry(1'h0);
      rdCtx(1'h1, ctxB);
      chk("runLevel", runLevel, LVL_HIGH);
      rdCtx(1'h0, ctxA);
      setSel(1'h1);
      d = 8'($urandom);
      access(1'h1, SHADOW_BANK, 1, d);
      ctxB.work = d;
      leave(1'h1, ctxB);
      leave(1'h1, ctxA);
      leave(1'h0, ctxA);
      priorityEnable <= 1'h0;
      ctxA = rnd();
      ld(ctxA);
      entry(1'h1);
      rdCtx(1'h0, ctxA);
      rdCtx(1'h1, ctxB);
      leave(1'h1, ctxA);
    end
    access(1'h0, SHADOW_BANK, 13, 8'h00);
    access(1'h0, SHADOW_BANK, 2, byteOf(ctxB, 2));
    access(1'h1, 6'h00, 2, ~byteOf(ctxB, 2));
    chk("shadowRdata", shadowRdata, byteOf(ctxB, 2));
    access(1'h0, 6'h00, 3, byteOf(ctxB, 2));
    access(1'h0, SHADOW_BANK, 2, byteOf(ctxB, 2));
    close_out();
  end
endmodule // testbench
